// [rtl/snep_top.sv]
// serial numeric entry and error parser top
`timescale 1ns/1ns
`include "snep_regs.svh"
module snep_top #(
  parameter int BIT_CYC = `SNEP_BIT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial link
  input wire logic rx_pin,
  output logic tx_pin,
  // error indication, active low
  output logic error_indicator_pin_n,
  // holding register, commands and error counter handed onward
  output logic [31:0] hold_r,
  output logic [7:0] hold_byte_r,
  output snep_pkg::snep_cmd_t cmd_r,
  output logic [7:0] err_cnt_r
);
  logic rs1_r, rst_s_n;
  snep_pkg::snep_byte_t rxb;
  snep_pkg::snep_state_t st_r, st_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic [3:0] ndig_r, ndig_nxt;
  logic any_r, any_nxt, late_r, late_nxt;
  logic [7:0] cchr_r, ch;
  logic term, isdig, hexok, first_ev, err_now, fin, fin_err, hold_ld;
  logic is_e, is_c, is_w, err_ev;
  logic [3:0] hval;
  logic [7:0] cnt_nxt;
  logic [7:0] msg_r [0:`SNEP_MSG_LEN-1];
  logic [2:0] msg_len_r, msg_idx_r;
  logic tx_go_r, tx_busy;
  logic [7:0] tx_dat_r;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_r <= 1'b0;
      rst_s_n <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rst_s_n <= rs1_r;
    end
  end

  snep_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk(ref_clk),
    .rst_n(rst_s_n),
    .rx_pin(rx_pin),
    .rx_byte(rxb)
  );

  snep_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(ref_clk),
    .rst_n(rst_s_n),
    .go(tx_go_r),
    .data(tx_dat_r),
    .busy(tx_busy),
    .tx_pin(tx_pin)
  );

  // character classes
  always_comb
  begin
    ch = rxb.data;
    term = ((ch < `SNEP_CH_SP) && (ch != `SNEP_CH_BS)) || (ch == `SNEP_CH_SP);
    isdig = (ch >= 8'h30) && (ch <= 8'h39);
    hexok = 1'b1;
    hval = ch[3:0];
    if (isdig)
      hval = ch[3:0];
    else if (((ch | 8'h20) >= 8'h61) && ((ch | 8'h20) <= 8'h66))
      hval = ch[3:0] + 4'h9;
    else
      hexok = 1'b0;
  end

  // entry parser
  always_comb
  begin
    st_nxt = st_r;
    acc_nxt = acc_r;
    ndig_nxt = ndig_r;
    any_nxt = any_r;
    late_nxt = late_r;
    first_ev = 1'b0;
    err_now = 1'b0;
    fin = 1'b0;
    fin_err = 1'b0;
    hold_ld = 1'b0;
    if (rxb.vld)
    begin
      case (st_r)
        snep_pkg::SNEP_ST_IDLE:
        begin
          if (term)
            fin = 1'b1;
          else
          begin
            first_ev = 1'b1;
            acc_nxt = 32'h0000_0000;
            ndig_nxt = 4'h0;
            any_nxt = 1'b0;
            late_nxt = 1'b0;
            if (ch == `SNEP_CH_DOLLAR)
              st_nxt = snep_pkg::SNEP_ST_HEX;
            else if (ch == `SNEP_CH_HASH)
              st_nxt = snep_pkg::SNEP_ST_DEC;
            else if (isdig)
            begin
              err_now = 1'b1;
              st_nxt = snep_pkg::SNEP_ST_SKIP;
            end
            else if (ch == `SNEP_CH_BS)
            begin
              late_nxt = 1'b1;
              st_nxt = snep_pkg::SNEP_ST_SKIP;
            end
            else
              st_nxt = snep_pkg::SNEP_ST_CMD;
          end
        end
        snep_pkg::SNEP_ST_HEX, snep_pkg::SNEP_ST_DEC:
        begin
          if (term)
          begin
            fin = 1'b1;
            st_nxt = snep_pkg::SNEP_ST_IDLE;
            if (any_r)
              hold_ld = 1'b1;
            else
            begin
              fin_err = 1'b1;
              err_now = 1'b1;
            end
          end
          else if (ch == `SNEP_CH_BS)
          begin
            late_nxt = 1'b1;
            st_nxt = snep_pkg::SNEP_ST_SKIP;
          end
          else if ((st_r == snep_pkg::SNEP_ST_HEX) ? !hexok : !isdig)
          begin
            err_now = 1'b1;
            st_nxt = snep_pkg::SNEP_ST_SKIP;
          end
          else
          begin
            any_nxt = 1'b1;
            if ((acc_r == 32'h0000_0000) && (hval == 4'h0))
              acc_nxt = acc_r;
            else if (ndig_r == `SNEP_MAX_DIG)
            begin
              err_now = 1'b1;
              st_nxt = snep_pkg::SNEP_ST_SKIP;
            end
            else
            begin
              ndig_nxt = ndig_r + 4'h1;
              if (st_r == snep_pkg::SNEP_ST_HEX)
                acc_nxt = {acc_r[27:0], hval};
              else
                acc_nxt = (acc_r << 3) + (acc_r << 1) + {28'h0, hval};
            end
          end
        end
        snep_pkg::SNEP_ST_CMD:
        begin
          if (term)
          begin
            fin = 1'b1;
            st_nxt = snep_pkg::SNEP_ST_IDLE;
          end
          else
          begin
            late_nxt = 1'b1;
            st_nxt = snep_pkg::SNEP_ST_SKIP;
          end
        end
        default:
        begin
          if (term)
          begin
            fin = 1'b1;
            fin_err = 1'b1;
            err_now = late_r;
            st_nxt = snep_pkg::SNEP_ST_IDLE;
          end
        end
      endcase
    end
  end

  // command decode at the terminator, exact case only
  always_comb
  begin
    is_e = fin && (st_r == snep_pkg::SNEP_ST_CMD) && (cchr_r == `SNEP_CMD_ERR);
    is_c = fin && (st_r == snep_pkg::SNEP_ST_CMD) && (cchr_r == `SNEP_CMD_CLR);
    is_w = fin && (st_r == snep_pkg::SNEP_ST_CMD) && (cchr_r == `SNEP_CMD_SHOW);
    err_ev = err_now | is_e;
    if (is_c)
      cnt_nxt = 8'h00;
    else if (err_ev && (err_cnt_r != `SNEP_ERR_MAX))
      cnt_nxt = err_cnt_r + 8'h01;
    else
      cnt_nxt = err_cnt_r;
  end

  always_ff @(posedge ref_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      st_r <= snep_pkg::SNEP_ST_IDLE;
      acc_r <= 32'h0000_0000;
      ndig_r <= 4'h0;
      any_r <= 1'b0;
      late_r <= 1'b0;
      cchr_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      acc_r <= acc_nxt;
      ndig_r <= ndig_nxt;
      any_r <= any_nxt;
      late_r <= late_nxt;
      if (first_ev)
        cchr_r <= ch;
    end
  end

  // holding register, untouched by rejected entries
  always_ff @(posedge ref_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      hold_r <= 32'h0000_0000;
      hold_byte_r <= 8'h00;
    end
    else if (hold_ld)
    begin
      hold_r <= acc_r;
      hold_byte_r <= acc_r[7:0];
    end
  end

  // other commands handed on with their exact letter
  always_ff @(posedge ref_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      cmd_r <= '0;
    else
    begin
      cmd_r.stb <= fin && (st_r == snep_pkg::SNEP_ST_CMD) && !is_e && !is_c && !is_w;
      if (fin)
        cmd_r.chr <= cchr_r;
    end
  end

  // lone terminators touch neither counter nor pin
  always_ff @(posedge ref_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      err_cnt_r <= 8'h00;
    else
      err_cnt_r <= cnt_nxt;
  end

  always_ff @(posedge ref_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      error_indicator_pin_n <= 1'b1;
    else if (err_ev)
      error_indicator_pin_n <= 1'b0;
    else if (first_ev || is_c)
      error_indicator_pin_n <= 1'b1;
  end

  // reply buffer; a reply is dropped if the previous one is still going
  always_ff @(posedge ref_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      msg_r[0] <= `SNEP_CH_BANG;
      for (int i = 1; i < `SNEP_MSG_LEN; i++)
        msg_r[i] <= 8'h00;
      msg_len_r <= 3'h1;
      msg_idx_r <= 3'h0;
      tx_go_r <= 1'b0;
      tx_dat_r <= 8'h00;
    end
    else
    begin
      tx_go_r <= 1'b0;
      if ((msg_idx_r == msg_len_r) && !tx_busy && !tx_go_r)
      begin
        if (fin && (fin_err || is_e))
        begin
          msg_r[0] <= `SNEP_CH_QUES;
          msg_r[1] <= `SNEP_CH_CR;
          msg_r[2] <= hex_ch(cnt_nxt[3:0]);
          msg_r[3] <= `SNEP_CH_GT;
          msg_len_r <= 3'h4;
          msg_idx_r <= 3'h0;
        end
        else if (is_w)
        begin
          msg_r[0] <= hex_ch(err_cnt_r[7:4]);
          msg_r[1] <= hex_ch(err_cnt_r[3:0]);
          msg_r[2] <= `SNEP_CH_CR;
          msg_r[3] <= hex_ch(cnt_nxt[3:0]);
          msg_r[4] <= `SNEP_CH_GT;
          msg_len_r <= 3'h5;
          msg_idx_r <= 3'h0;
        end
        else if (fin)
        begin
          msg_r[0] <= hex_ch(cnt_nxt[3:0]);
          msg_r[1] <= `SNEP_CH_GT;
          msg_len_r <= 3'h2;
          msg_idx_r <= 3'h0;
        end
      end
      else if ((msg_idx_r != msg_len_r) && !tx_busy && !tx_go_r)
      begin
        tx_go_r <= 1'b1;
        tx_dat_r <= msg_r[msg_idx_r];
        msg_idx_r <= msg_idx_r + 3'h1;
      end
    end
  end
endmodule // snep_top

// [rtl/snep_regs.svh]
// constants of the serial numeric entry and error parser
// Functional notes
// - hex entry is dollar then digits, terminated
// - bad hex digit aborts, errors, pin low
// - leading zeros ignored, max eight significant digits
// - upper and lower hex letters equal
// - byte commands use low holding byte
// - decimal entry hash, eight digits 0-9
// - valid entries load the holding register
// - digits without prefix are an error
// - rejected entry keeps holding register unchanged
// - CR, LF, space, control codes except backspace terminate
// - backspace invalidates entry, error at terminator
// - error pin low on error, high next entry
// - lone terminators leave pin and counter alone
// - eight-bit saturating error counter
// - prompt is low count nibble then '>'
// - question mark then CR then prompt
// - reset sends one exclamation mark only
// - force-error command acts as an error
// - clear command alone clears the counter
// - show-count sends counter as two hex
// - command letters are case sensitive
// - link is 9600 baud 8N1, no echo
`ifndef SNEP_REGS_SVH
`define SNEP_REGS_SVH
`define SNEP_CLK_HZ 100000000
`define SNEP_BAUD 9600
`define SNEP_BIT_CYC (`SNEP_CLK_HZ / `SNEP_BAUD)
`define SNEP_CH_BANG 8'h21
`define SNEP_CH_QUES 8'h3f
`define SNEP_CH_GT 8'h3e
`define SNEP_CH_CR 8'h0d
`define SNEP_CH_SP 8'h20
`define SNEP_CH_BS 8'h08
`define SNEP_CH_DOLLAR 8'h24
`define SNEP_CH_HASH 8'h23
`define SNEP_CMD_ERR 8'h65
`define SNEP_CMD_CLR 8'h63
`define SNEP_CMD_SHOW 8'h77
`define SNEP_ERR_MAX 8'hff
`define SNEP_MAX_DIG 4'h8
`define SNEP_MSG_LEN 5
`endif

// [rtl/snep_pkg.sv]
// types of the serial numeric entry and error parser
package snep_pkg;
  typedef struct packed {
    logic vld;
    logic [7:0] data;
  } snep_byte_t;
  typedef struct packed {
    logic stb;
    logic [7:0] chr;
  } snep_cmd_t;
  typedef enum logic [4:0] {
    SNEP_ST_IDLE = 5'b00001,
    SNEP_ST_HEX = 5'b00010,
    SNEP_ST_DEC = 5'b00100,
    SNEP_ST_CMD = 5'b01000,
    SNEP_ST_SKIP = 5'b10000
  } snep_state_t;
endpackage

// [rtl/snep_uart_rx.sv]
// serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
module snep_uart_rx #(
  parameter int BIT_CYC = 10416
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial line
  input wire logic rx_pin,
  // received byte
  output snep_pkg::snep_byte_t rx_byte
);
  logic s1_r, s2_r, s3_r, lvl_r;
  logic [1:0] ph_r;
  logic [15:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
    end
    else
    begin
      s1_r <= rx_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        lvl_r <= s3_r;
    end
  end

  // ph 0 idle, 1 start, 2 data, 3 stop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_r <= 2'h0;
      cnt_r <= 16'h0000;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      rx_byte <= '0;
    end
    else
    begin
      rx_byte.vld <= 1'b0;
      if (cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
      else
      begin
        case (ph_r)
          2'h0:
          begin
            if (!lvl_r)
            begin
              ph_r <= 2'h1;
              cnt_r <= 16'(BIT_CYC / 2);
            end
          end
          2'h1:
          begin
            ph_r <= lvl_r ? 2'h0 : 2'h2;
            cnt_r <= 16'(BIT_CYC - 1);
            bit_r <= 3'h0;
          end
          2'h2:
          begin
            sh_r <= {lvl_r, sh_r[7:1]};
            bit_r <= bit_r + 3'h1;
            cnt_r <= 16'(BIT_CYC - 1);
            if (bit_r == 3'h7)
              ph_r <= 2'h3;
          end
          default:
          begin
            ph_r <= 2'h0;
            if (lvl_r)
            begin
              rx_byte.vld <= 1'b1;
              rx_byte.data <= sh_r;
            end
          end
        endcase
      end
    end
  end
endmodule // snep_uart_rx

// [rtl/snep_uart_tx.sv]
// serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
module snep_uart_tx #(
  parameter int BIT_CYC = 10416
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte to send
  input wire logic go,
  input wire logic [7:0] data,
  output logic busy,
  // serial line
  output logic tx_pin
);
  logic [9:0] sh_r;
  logic [3:0] left_r;
  logic [15:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_r <= 10'h3ff;
      left_r <= 4'h0;
      cnt_r <= 16'h0000;
      busy <= 1'b0;
      tx_pin <= 1'b1;
    end
    else if (!busy)
    begin
      if (go)
      begin
        sh_r <= {1'b1, data, 1'b0};
        left_r <= 4'ha;
        cnt_r <= 16'h0000;
        busy <= 1'b1;
      end
    end
    else if (cnt_r != 16'h0000)
      cnt_r <= cnt_r - 16'h0001;
    else if (left_r == 4'h0)
      busy <= 1'b0;
    else
    begin
      tx_pin <= sh_r[0];
      sh_r <= {1'b1, sh_r[9:1]};
      left_r <= left_r - 4'h1;
      cnt_r <= 16'(BIT_CYC - 1);
    end
  end
endmodule // snep_uart_tx

// [sim/snep_top_monitor.sv]
// port assertions of the serial numeric entry and error parser
`timescale 1ns/1ns
module snep_top_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial link
  input wire logic rx_pin,
  input wire logic tx_pin,
  // parser outputs
  input wire logic error_indicator_pin_n,
  input wire logic [31:0] hold_r,
  input wire logic [7:0] hold_byte_r,
  input wire snep_pkg::snep_cmd_t cmd_r,
  input wire logic [7:0] err_cnt_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_low_byte;
    hold_byte_r == hold_r[7:0];
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte mismatch");
  property p_cnt_step;
    $changed(err_cnt_r) |-> err_cnt_r == $past(err_cnt_r) + 8'h01 || err_cnt_r == 8'h00;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
  property p_err_pin;
    $changed(err_cnt_r) && err_cnt_r != 8'h00 |-> ##[0:1] !error_indicator_pin_n;
  endproperty
  a_err_pin: assert property (p_err_pin) else $error("error without pin low");
  property p_clr_pin;
    $changed(err_cnt_r) && err_cnt_r == 8'h00 |-> error_indicator_pin_n;
  endproperty
  a_clr_pin: assert property (p_clr_pin) else $error("clear left pin low");
  property p_cmd_pulse;
    cmd_r.stb |=> !cmd_r.stb;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
  property p_cmd_ok;
    cmd_r.stb |-> $stable(err_cnt_r) && error_indicator_pin_n;
  endproperty
  a_cmd_ok: assert property (p_cmd_ok) else $error("command with error");
  property p_cmd_own;
    cmd_r.stb |-> !(cmd_r.chr inside {8'h65, 8'h63, 8'h77}) && cmd_r.chr > 8'h20;
  endproperty
  a_cmd_own: assert property (p_cmd_own) else $error("internal letter passed on");
  property p_hold_ok;
    $changed(hold_r) |-> $stable(err_cnt_r) && error_indicator_pin_n;
  endproperty
  a_hold_ok: assert property (p_hold_ok) else $error("hold changed on error");
  c_cmd: cover property (cmd_r.stb);
  c_hold: cover property ($changed(hold_r));
  c_clr: cover property ($fell(err_cnt_r != 8'h00));
endmodule // snep_top_monitor
bind snep_top snep_top_monitor u_mon (.ref_clk, .rst_n, .rx_pin, .tx_pin,
  .error_indicator_pin_n, .hold_r, .hold_byte_r, .cmd_r, .err_cnt_r);

// [sim/snep_host_model.sv]
// serial terminal model: types characters, collects replies
`timescale 1ns/1ns
module snep_host_model #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic ref_clk,
  // serial link, terminal view
  output logic host_tx,
  input wire logic host_rx
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  initial host_tx = 1'b1;
  // one frame, lsb first, idle high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    @(negedge ref_clk);
    for (int i = 0; i < 10; i++)
    begin
      host_tx = frame[i];
      repeat (BIT_CYC) @(negedge ref_clk);
    end
  endtask
  always
  begin
    @(negedge host_rx);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge ref_clk);
      rx_b[i] = host_rx;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    if (host_rx)
      rx_q.push_back(rx_b);
  end
endmodule // snep_host_model

// [sim/tb.sv]
// testbench of the serial numeric entry and error parser
`timescale 1ns/1ns
module tb;
  localparam int BC = 16;
  logic ref_clk;
  logic rst_n;
  logic rx_pin;
  logic tx_pin;
  logic error_indicator_pin_n;
  logic [31:0] hold_r;
  logic [7:0] hold_byte_r;
  snep_pkg::snep_cmd_t cmd_r;
  logic [7:0] err_cnt_r;
  logic [7:0] last_cmd;
  int miscompares = 0;
  int total_checks = 0;
  int ecnt = 0;
  int ncmd = 0;
  snep_top #(.BIT_CYC(BC)) dut (.ref_clk, .rst_n, .rx_pin, .tx_pin,
    .error_indicator_pin_n, .hold_r, .hold_byte_r, .cmd_r, .err_cnt_r);
  snep_host_model #(.BIT_CYC(BC)) host (.ref_clk, .host_tx(rx_pin), .host_rx(tx_pin));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (cmd_r.stb === 1'b1)
    begin
      last_cmd <= cmd_r.chr;
      ncmd <= ncmd + 1;
    end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic string prompt();
    return $sformatf("%h>", ecnt[3:0]);
  endfunction
  function automatic string errs();
    return {"?\015", prompt()};
  endfunction
  task automatic send_str(input string s, input int gap);
    foreach (s[i])
    begin
      host.send_byte(s[i]);
      repeat (gap) @(negedge ref_clk);
    end
  endtask
  // waits for the whole reply, then a quiet frame for extra bytes
  task automatic exp_reply(input string s);
    int n;
    n = 0;
    while (host.rx_q.size() < s.len())
    begin
      @(negedge ref_clk);
      n++;
      if (n > 400 * BC)
      begin
        miscompares++;
        final_report();
      end
    end
    repeat (12 * BC) @(negedge ref_clk);
    chk(host.rx_q.size(), s.len());
    foreach (s[i])
      chk(host.rx_q[i], s[i]);
    host.rx_q.delete();
  endtask
  task automatic t_reset();
    rst_n = 1'b0;
    ecnt = 0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    exp_reply("!");
    chk(err_cnt_r, 8'h00);
    chk(hold_r, 32'h0);
    chk(error_indicator_pin_n, 1'b1);
    $display("done reset");
  endtask
  task automatic t_hex();
    send_str("$00ABcd1234\015", 0);
    exp_reply(prompt());
    chk(hold_r, 32'habcd1234);
    chk(hold_byte_r, 8'h34);
    $display("done hex");
  endtask
  task automatic t_dec();
    send_str("#0004567 ", 3);
    exp_reply(prompt());
    chk(hold_r, 32'h000011d7);
    send_str("#0099999999\n", 0);
    exp_reply(prompt());
    chk(hold_r, 32'h05f5e0ff);
    send_str("#123456789\n", 0);
    ecnt++;
    exp_reply(errs());
    chk(hold_r, 32'h05f5e0ff);
    $display("done dec");
  endtask
  task automatic t_hexerr();
    send_str("$12g", 0);
    repeat (4) @(negedge ref_clk);
    chk(error_indicator_pin_n, 1'b0);
    send_str("34\015", 0);
    ecnt++;
    exp_reply(errs());
    send_str("$123456789\015", 0);
    ecnt++;
    exp_reply(errs());
    chk(err_cnt_r, 8'h03);
    chk(hold_r, 32'h05f5e0ff);
    $display("done hexerr");
  endtask
  task automatic t_pin();
    send_str("5\015", 0);
    ecnt++;
    exp_reply(errs());
    send_str("\015", 0);
    exp_reply(prompt());
    chk(error_indicator_pin_n, 1'b0);
    chk(err_cnt_r, 8'h04);
    send_str("$", 0);
    repeat (4) @(negedge ref_clk);
    chk(error_indicator_pin_n, 1'b1);
    send_str("7\015", 0);
    exp_reply(prompt());
    chk(hold_r, 32'h7);
    $display("done pin");
  endtask
  task automatic t_bs();
    send_str("$1\0102\015", 0);
    ecnt++;
    exp_reply(errs());
    chk(hold_r, 32'h7);
    chk(error_indicator_pin_n, 1'b0);
    $display("done bs");
  endtask
  task automatic t_cmd();
    logic [7:0] term [4] = '{8'h0d, 8'h0a, 8'h20, 8'h03};
    foreach (term[i])
    begin
      host.send_byte(i[0] ? 8'h41 : 8'h61);
      host.send_byte(term[i]);
      exp_reply(prompt());
      chk(last_cmd, i[0] ? 8'h41 : 8'h61);
    end
    send_str("ab ", 0);
    ecnt++;
    exp_reply(errs());
    chk(ncmd, 4);
    $display("done cmd");
  endtask
  task automatic t_errcmd();
    send_str("E\015", 0);
    exp_reply(prompt());
    chk(last_cmd, 8'h45);
    chk(err_cnt_r, 8'h06);
    send_str("e\015", 0);
    ecnt++;
    exp_reply(errs());
    chk(error_indicator_pin_n, 1'b0);
    send_str("w ", 0);
    exp_reply($sformatf("%h\015%h>", ecnt[7:0], ecnt[3:0]));
    send_str("c\015", 0);
    ecnt = 0;
    exp_reply(prompt());
    chk(err_cnt_r, 8'h00);
    chk(error_indicator_pin_n, 1'b1);
    send_str("$\015", 0);
    ecnt++;
    exp_reply(errs());
    send_str("#1a\015", 0);
    ecnt++;
    exp_reply(errs());
    chk(err_cnt_r, 8'h02);
    $display("done errcmd");
  endtask
  initial
  begin
    t_reset();
    t_hex();
    t_dec();
    t_hexerr();
    t_pin();
    t_bs();
    t_cmd();
    t_errcmd();
    t_reset();
    final_report();
  end
endmodule // tb
